// ### vectored_interrupt_controller.sv
`timescale 1ns/1ps
// Summary of operation
// - taking an interrupt clears the global enable
// - events still latch flags while globally disabled
// - no acceptance while the return stack is full
// - requests are taken on sampling clock rise
// - fixed order: pin0, timer, conv, ser0, ser1, pin1
// - pin1 promotion over internal sources is optional
// - falling pin edge sets that pin's flag
// - service needs global and per-source enable
// - pin0 vectors to 04h, pin1 to 018h
// - timer overflow sets flag, vectors to 08h
// - conversion done sets flag, vectors to 0ch
// - each serial byte done sets its flag
// - serial0 vectors to 10h, serial1 to 14h
// - serial service also needs serial bus enable
// - service clears only served flag and global enable
// - flags persist until served or written clear
// - any pending flag raises the wake request
// - only the program counter is pushed
// - unimplemented secondary bits read as zero
// - push next address, then load the vector
module vectored_interrupt_controller
  import vic_pkg::*;
#(
  parameter bit EXT1_OVER_INTERNAL = 1'b0
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_irq_pin0,
  input  wire logic              ext_irq_pin1,
  input  wire irq_events_t       events,
  input  wire logic              serial_bus_enable,
  input  wire logic              sampling_phase_clock,
  input  wire logic              stack_full,
  input  wire logic [PC_W-1:0]   next_pc,
  input  wire logic              reti_done,
  output irq_entry_t             irq_entry,
  output logic                   wake_request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                   gie_reg;
  logic                   test_mode_reg;
  logic [NUM_SRC-1:0]     enable_reg;
  logic [NUM_SRC-1:0]     flag_reg;
  logic [NUM_SRC-1:0]     flag_next;
  logic [1:0]             pin_prev_reg;
  logic [1:0]             pin_fall;
  logic                   spc_prev_reg;
  logic                   sample_edge;
  logic [NUM_SRC-1:0]     ready_req;
  logic                   grant_valid;
  logic [IDX_W-1:0]       grant_idx;
  logic                   take;
  logic [NUM_SRC-1:0]     set_event;
  logic [PC_W-1:0]        last_vector_reg;
  irq_entry_t             entry_reg;
  logic                   wake_reg;
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [ADDR_W-1:0]      awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  logic                   do_write;
  logic                   wr_primary;
  logic                   wr_secondary;
  logic [7:0]             primary_view;
  logic [7:0]             secondary_view;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  // pins idle high, so the history starts high to avoid a false edge
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      logic pin_now;
      assign pin_now     = (p == 0) ? ext_irq_pin0 : ext_irq_pin1;
      assign pin_fall[p] = pin_prev_reg[p] & ~pin_now;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_prev_reg[p] <= 1'b1;
        end else begin
          pin_prev_reg[p] <= pin_now;
        end
      end
    end
  endgenerate

  // sampling phase rising edge is the only moment a request is taken
  assign sample_edge = sampling_phase_clock & ~spc_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spc_prev_reg <= 1'b0;
    end else begin
      spc_prev_reg <= sampling_phase_clock;
    end
  end

  // ----------------------------------------------------------------
  // request set events, in source index order
  // ----------------------------------------------------------------
  assign set_event[SRC_EXT0] = pin_fall[0];
  assign set_event[SRC_TMR]  = events.timer_overflow;
  assign set_event[SRC_CONV] = events.conv_done;
  assign set_event[SRC_SER0] = events.serial0_done;
  assign set_event[SRC_SER1] = events.serial1_done;
  assign set_event[SRC_EXT1] = pin_fall[1];

  // ----------------------------------------------------------------
  // arbitration and acceptance
  // ----------------------------------------------------------------
  // serial sources also wait for the serial bus to be switched on
  always_comb begin
    ready_req = flag_reg & enable_reg;
    if (!serial_bus_enable) begin
      ready_req[SRC_SER0] = 1'b0;
      ready_req[SRC_SER1] = 1'b0;
    end
  end

  irq_priority_select #(
    .EXT1_OVER_INTERNAL (EXT1_OVER_INTERNAL)
  ) u_select (
    .ready_req   (ready_req),
    .grant_valid (grant_valid),
    .grant_idx   (grant_idx)
  );

  // a full stack holds everything off; flags stay pending meanwhile
  assign take = sample_edge & gie_reg & grant_valid & ~stack_full;

  // the core pushes push_pc, then jumps to vector; nothing else saved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_reg       <= '0;
      last_vector_reg <= '0;
    end else begin
      entry_reg.accept <= take;
      if (take) begin
        entry_reg.push_pc <= next_pc;
        entry_reg.vector  <= vector_of(grant_idx);
        last_vector_reg   <= vector_of(grant_idx);
      end
    end
  end

  assign irq_entry = entry_reg;

  // ----------------------------------------------------------------
  // register bus decode helpers
  // ----------------------------------------------------------------
  assign do_write     = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_primary   = do_write & wstrb_reg[0] & (awaddr_reg == OFS_PRIMARY);
  assign wr_secondary = do_write & wstrb_reg[0] & (awaddr_reg == OFS_SECONDARY);

  // ----------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------
  // acceptance beats a return or a write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_reg <= 1'b0;
    end else if (take) begin
      gie_reg <= 1'b0;
    end else if (reti_done) begin
      gie_reg <= 1'b1;
    end else if (wr_primary) begin
      gie_reg <= wdata_reg[P_GIE];
    end
  end

  // ----------------------------------------------------------------
  // enables and test bit
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg    <= '0;
      test_mode_reg <= 1'b0;
    end else begin
      if (wr_primary) begin
        enable_reg[SRC_EXT0] <= wdata_reg[P_EXT0_EN];
        enable_reg[SRC_TMR]  <= wdata_reg[P_TMR_EN];
        enable_reg[SRC_CONV] <= wdata_reg[P_CONV_EN];
        test_mode_reg        <= wdata_reg[P_TEST]; // stored only, no effect
      end
      if (wr_secondary) begin
        enable_reg[SRC_SER0] <= wdata_reg[S_SER0_EN];
        enable_reg[SRC_SER1] <= wdata_reg[S_SER1_EN];
        enable_reg[SRC_EXT1] <= wdata_reg[S_EXT1_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // write first, then service clear, then events: a set always wins
  always_comb begin
    flag_next = flag_reg;
    if (wr_primary) begin
      flag_next[SRC_EXT0] = wdata_reg[P_EXT0_F];
      flag_next[SRC_TMR]  = wdata_reg[P_TMR_F];
      flag_next[SRC_CONV] = wdata_reg[P_CONV_F];
    end
    if (wr_secondary) begin
      flag_next[SRC_SER0] = wdata_reg[S_SER0_F];
      flag_next[SRC_SER1] = wdata_reg[S_SER1_F];
      flag_next[SRC_EXT1] = wdata_reg[S_EXT1_F];
    end
    if (take) begin
      flag_next[grant_idx] = 1'b0;
    end
    flag_next = flag_next | set_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // wake request
  // ----------------------------------------------------------------
  // any latched flag wakes the core, whatever the enables say
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |flag_reg;
    end
  end

  assign wake_request = wake_reg;

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  always_comb begin
    primary_view            = '0;
    primary_view[P_GIE]     = gie_reg;
    primary_view[P_EXT0_EN] = enable_reg[SRC_EXT0];
    primary_view[P_TMR_EN]  = enable_reg[SRC_TMR];
    primary_view[P_CONV_EN] = enable_reg[SRC_CONV];
    primary_view[P_EXT0_F]  = flag_reg[SRC_EXT0];
    primary_view[P_TMR_F]   = flag_reg[SRC_TMR];
    primary_view[P_CONV_F]  = flag_reg[SRC_CONV];
    primary_view[P_TEST]    = test_mode_reg;
    secondary_view            = '0;
    secondary_view[S_SER0_EN] = enable_reg[SRC_SER0];
    secondary_view[S_SER1_EN] = enable_reg[SRC_SER1];
    secondary_view[S_EXT1_EN] = enable_reg[SRC_EXT1];
    secondary_view[S_SER0_F]  = flag_reg[SRC_SER0];
    secondary_view[S_SER1_F]  = flag_reg[SRC_SER1];
    secondary_view[S_EXT1_F]  = flag_reg[SRC_EXT1];
    secondary_view = secondary_view & SEC_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may come in either order; one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (awaddr_reg == OFS_PRIMARY || awaddr_reg == OFS_SECONDARY)
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
      case (s_axi_araddr)
        OFS_PRIMARY:   rdata_reg[7:0] <= primary_view;
        OFS_SECONDARY: rdata_reg[7:0] <= secondary_view;
        OFS_STATUS: begin
          rdata_reg[ST_STACK_FULL]                  <= stack_full;
          rdata_reg[ST_WAKE]                        <= wake_reg;
          rdata_reg[ST_LAST_LO +: PC_W]             <= last_vector_reg;
        end
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ready_at_sample;
    sample_edge && gie_reg && !stack_full && (ready_req != '0);
  endsequence

  sequence s_entry_pulse;
    entry_reg.accept;
  endsequence

  chk_accept_clears_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    s_entry_pulse |-> !gie_reg)
    else $error("global enable still set after acceptance");

  chk_pending_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (!gie_reg && events.timer_overflow) |=> flag_reg[SRC_TMR])
    else $error("timer event lost while globally disabled");

  chk_stack_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(stack_full) |-> !entry_reg.accept)
    else $error("acceptance with a full stack");

  chk_sample_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ready_at_sample |=> s_entry_pulse)
    else $error("ready request not taken at sampling edge");

  chk_only_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    s_entry_pulse |-> $past(sample_edge))
    else $error("acceptance away from a sampling edge");

  chk_pin_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(ext_irq_pin0) && !ext_irq_pin0) |=> flag_reg[SRC_EXT0])
    else $error("falling pin0 edge did not set its flag");

  chk_vector_match: assert property (@(posedge aclk) disable iff (!aresetn)
    s_entry_pulse |-> entry_reg.vector == vector_of($past(grant_idx)))
    else $error("vector does not match the granted source");

  chk_top_priority: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && ready_req[SRC_EXT0]) |=> entry_reg.vector == VEC_EXT0)
    else $error("pin0 lost arbitration");

  // with the table order in force the grant must be the lowest ready index
  chk_single_grant: assert property (@(posedge aclk) disable iff (!aresetn)
    (grant_valid && !EXT1_OVER_INTERNAL)
      |-> ready_req[grant_idx] && (ready_req & ~({NUM_SRC{1'b1}} << grant_idx)) == '0)
    else $error("grant is not the highest ready source");

  chk_serial_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (entry_reg.accept && entry_reg.vector == VEC_SER0) |-> $past(serial_bus_enable))
    else $error("serial request served with the serial bus off");

  chk_served_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && grant_idx == SRC_CONV && !events.conv_done && !wr_primary)
      |=> !flag_reg[SRC_CONV])
    else $error("served flag not cleared");

  chk_flag_persist: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_reg[SRC_TMR] && !wr_primary && !(take && grant_idx == SRC_TMR))
      |=> flag_reg[SRC_TMR])
    else $error("timer flag dropped on its own");

  chk_wake_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_reg != '0) |=> wake_request)
    else $error("pending flag without wake request");

  chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_SECONDARY)
      |=> (s_axi_rdata[7:0] & ~SEC_IMPL_MASK) == 8'h00)
    else $error("unimplemented secondary bits read nonzero");

endmodule

// ### vic_pkg.sv
package vic_pkg;

  // ----------------------------------------------------------------
  // widths and source numbering
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int IDX_W   = 3;
  localparam int PC_W    = 11;
  localparam int ADDR_W  = 8;

  // source index doubles as the fixed priority, 0 is served first
  localparam logic [IDX_W-1:0] SRC_EXT0 = 3'h0;
  localparam logic [IDX_W-1:0] SRC_TMR  = 3'h1;
  localparam logic [IDX_W-1:0] SRC_CONV = 3'h2;
  localparam logic [IDX_W-1:0] SRC_SER0 = 3'h3;
  localparam logic [IDX_W-1:0] SRC_SER1 = 3'h4;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 3'h5;

  // ----------------------------------------------------------------
  // vector addresses
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] VEC_EXT0 = 11'h004;
  localparam logic [PC_W-1:0] VEC_TMR  = 11'h008;
  localparam logic [PC_W-1:0] VEC_CONV = 11'h00c;
  localparam logic [PC_W-1:0] VEC_SER0 = 11'h010;
  localparam logic [PC_W-1:0] VEC_SER1 = 11'h014;
  localparam logic [PC_W-1:0] VEC_EXT1 = 11'h018;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PRIMARY   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SECONDARY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h08;

  // irq_control_primary fields
  localparam int P_GIE     = 0;
  localparam int P_EXT0_EN = 1;
  localparam int P_TMR_EN  = 2;
  localparam int P_CONV_EN = 3;
  localparam int P_EXT0_F  = 4;
  localparam int P_TMR_F   = 5;
  localparam int P_CONV_F  = 6;
  localparam int P_TEST    = 7;
  // irq_control_secondary fields, bits 3 and 7 unimplemented
  localparam int S_SER0_EN = 0;
  localparam int S_SER1_EN = 1;
  localparam int S_EXT1_EN = 2;
  localparam int S_SER0_F  = 4;
  localparam int S_SER1_F  = 5;
  localparam int S_EXT1_F  = 6;
  localparam logic [7:0] SEC_IMPL_MASK = 8'h77;
  // status word fields
  localparam int ST_STACK_FULL = 0;
  localparam int ST_WAKE       = 1;
  localparam int ST_LAST_LO    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer_overflow;
    logic conv_done;
    logic serial0_done;
    logic serial1_done;
  } irq_events_t;

  typedef struct packed {
    logic            accept;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] vector;
  } irq_entry_t;

  function automatic logic [PC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    case (idx)
      SRC_EXT0: vector_of = VEC_EXT0;
      SRC_TMR:  vector_of = VEC_TMR;
      SRC_CONV: vector_of = VEC_CONV;
      SRC_SER0: vector_of = VEC_SER0;
      SRC_SER1: vector_of = VEC_SER1;
      default:  vector_of = VEC_EXT1;
    endcase
  endfunction

endpackage

// ### irq_priority_select.sv
`timescale 1ns/1ps
module irq_priority_select
  import vic_pkg::*;
#(
  parameter bit EXT1_OVER_INTERNAL = 1'b0
) (
  input  wire logic [NUM_SRC-1:0] ready_req,
  output logic                    grant_valid,
  output logic [IDX_W-1:0]        grant_idx
);

  // --------------------------------------------------------------
  // fixed priority pick
  // --------------------------------------------------------------
  // scan from lowest priority upward so the last hit is the winner
  always_comb begin
    grant_valid = |ready_req;
    grant_idx   = SRC_EXT1;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (ready_req[i]) begin
        grant_idx = IDX_W'(i);
      end
    end
    // optional promotion of the second pin over internal sources
    if (EXT1_OVER_INTERNAL && ready_req[SRC_EXT1] && !ready_req[SRC_EXT0]) begin
      grant_idx = SRC_EXT1;
    end
  end

endmodule

// ### core_model.sv
`timescale 1ns/1ps
module core_model
  import vic_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            full_cmd,
  input  wire logic            ret_cmd,
  output logic                 sampling_phase_clock,
  output logic                 stack_full,
  output logic [PC_W-1:0]      next_pc,
  output logic                 reti_done
);
  // ----------------------------------------------------------------
  // sequencer: phase divider, program counter, return strobe
  // ----------------------------------------------------------------
  logic [1:0] div_reg;

  // the core only ever hands over its program counter, never acc or status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg   <= 2'h0;
      next_pc   <= 11'h000;
      reti_done <= 1'b0;
    end else begin
      div_reg   <= div_reg + 2'h1;
      next_pc   <= next_pc + 11'h001;
      reti_done <= ret_cmd;
    end
  end

  assign sampling_phase_clock = div_reg[1];
  // fullness is commanded, a handler never nests calls here
  assign stack_full = full_cmd;
endmodule

// ### vectored_interrupt_controller_test.sv
`timescale 1ns/1ps
module vectored_interrupt_controller_test
  import vic_pkg::*;
;
  typedef struct packed {
    logic [7:0]      en_p, fl_p, en_s, fl_s;
    logic [PC_W-1:0] vec;
  } row_t;
  row_t rows [6] = '{'{8'h02, 8'h10, 8'h00, 8'h00, 11'h004}, '{8'h04, 8'h20, 8'h00, 8'h00, 11'h008},
    '{8'h08, 8'h40, 8'h00, 8'h00, 11'h00c}, '{8'h00, 8'h00, 8'h01, 8'h10, 11'h010},
    '{8'h00, 8'h00, 8'h02, 8'h20, 11'h014}, '{8'h00, 8'h00, 8'h04, 8'h40, 11'h018}};
  logic            aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic            s_axi_rready, ext_irq_pin0, ext_irq_pin1, serial_bus_enable, ok, ret_cmd;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic            sampling_phase_clock, stack_full, reti_done, wake_request, full_cmd;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, d;
  logic [1:0]      s_axi_bresp, s_axi_rresp, r;
  logic [PC_W-1:0] next_pc;
  irq_events_t     events;
  irq_entry_t      irq_entry;
  int              error_cnt = 0;
  int              n_compared = 0;

  vectored_interrupt_controller dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_irq_pin0, .ext_irq_pin1, .events, .serial_bus_enable,
    .sampling_phase_clock, .stack_full, .next_pc, .reti_done, .irq_entry, .wake_request);
  core_model core_u (.aclk, .aresetn, .full_cmd, .ret_cmd, .sampling_phase_clock,
    .stack_full, .next_pc, .reti_done);

  // ----------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #20 aclk = ~aclk;

  // whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    #(40 * 20000);
    error_cnt++;
    final_report();
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta |= s_axi_awvalid & s_axi_awready;
      tw |= s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // pins fall for one cycle, internal events pulse for one cycle
  task automatic fire(input int s);
    @(posedge aclk);
    if (s == 0) ext_irq_pin0 <= 1'b0;
    else if (s == 5) ext_irq_pin1 <= 1'b0;
    else events[4-s] <= 1'b1;
    @(posedge aclk);
    ext_irq_pin0 <= 1'b1;
    ext_irq_pin1 <= 1'b1;
    events       <= '0;
  endtask

  // sixteen cycles span four sampling instants
  task automatic wait_acc();
    ok = 1'b0;
    repeat (16) begin
      @(negedge aclk);
      if (irq_entry.accept === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask

  task automatic ret();
    @(posedge aclk);
    ret_cmd <= 1'b1;
    @(posedge aclk);
    ret_cmd <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, full_cmd, ret_cmd, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ext_irq_pin0, ext_irq_pin1, serial_bus_enable} = 3'h7;
    events = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_PRIMARY);
    chk(d, 32'h0000_0000);
    rd(8'h0c);
    chk(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0000_0001);
    chk(r, RESP_SLVERR);
    wr(OFS_SECONDARY, 32'h0000_00ff);
    rd(OFS_SECONDARY);
    chk(d, 32'h0000_0077);
    wr(OFS_SECONDARY, 32'h0000_0000);
    $display("register access done");
    foreach (rows[i]) begin
      wr(OFS_SECONDARY, rows[i].en_s);
      wr(OFS_PRIMARY, rows[i].en_p);
      fire(i);
      rd(OFS_PRIMARY);
      chk(d, rows[i].en_p | rows[i].fl_p);
      rd(OFS_SECONDARY);
      chk(d, rows[i].en_s | rows[i].fl_s);
      chk(wake_request, 1'b1);
      wr(OFS_PRIMARY, rows[i].en_p | rows[i].fl_p | 8'h01);
      wait_acc();
      chk(irq_entry.vector, rows[i].vec);
      chk(irq_entry.push_pc, PC_W'(next_pc - 11'h001));
      rd(OFS_PRIMARY);
      chk(d, rows[i].en_p);
      rd(OFS_SECONDARY);
      chk(d, rows[i].en_s);
      ret();
      rd(OFS_PRIMARY);
      chk(d, rows[i].en_p | 8'h01);
      wr(OFS_PRIMARY, 32'h0000_0000);
      wr(OFS_SECONDARY, 32'h0000_0000);
      $display("source %0d done", i);
    end
    // four sources pending at once are served one at a time, in order
    for (int s = 1; s < 6; s++) if (s != 4) fire(s);
    wr(OFS_SECONDARY, 32'h0000_0055);
    wr(OFS_PRIMARY, 32'h0000_006d);
    foreach (rows[i]) if (i != 0 && i != 4) begin
      wait_acc();
      chk(irq_entry.vector, rows[i].vec);
      wait_acc();
      chk(ok, 1'b0);
      ret();
    end
    $display("priority done");
    full_cmd <= 1'b1;
    fire(1);
    wr(OFS_PRIMARY, 32'h0000_0025);
    wait_acc();
    chk(ok, 1'b0);
    rd(OFS_STATUS);
    chk(d, 32'h0000_1803);
    full_cmd <= 1'b0;
    wait_acc();
    chk(irq_entry.vector, 11'h008);
    $display("stack full done");
    // serial request held off while the serial bus is switched off
    wr(OFS_SECONDARY, 32'h0000_0011);
    serial_bus_enable <= 1'b0;
    wr(OFS_PRIMARY, 32'h0000_0001);
    wait_acc();
    chk(ok, 1'b0);
    @(posedge aclk);
    serial_bus_enable <= 1'b1;
    wait_acc();
    chk(irq_entry.vector, 11'h010);
    $display("serial gate done");
    // reset again in mid-run: enables and entry outputs return to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_SECONDARY);
    chk(d, 32'h0000_0000);
    chk(irq_entry, 32'h0000_0000);
    $display("mid-run reset done");
    final_report();
  end
endmodule
